/* capture_unit.sv */
// Purpose: Input capture unit with its registers on an APB slave.
// Assumes: Pin input synchronous to clk_i; 250 MHz clock.
// Notes: Compare and PWM encodings store but do not act here.
`timescale 1ns/100ps
module capture_unit
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Capture pin, three-signal form
    input wire logic capture_pin_i,
    output logic capture_pin_o,
    output logic capture_pin_oe_o,
    // Interrupt
    output logic irq_o
);

    // Register state
    logic [7:0] cap_low_q;
    logic [7:0] cap_high_q;
    logic [7:0] unit_ctrl_q;
    logic [7:0] core_irq_q;
    logic [7:0] periph_en_q;
    logic [7:0] periph_flags_q;
    logic [7:0] t2_period_q;
    logic [7:0] t2_count_q;
    logic [7:0] portb_dir_q;
    logic [7:0] portb_data_q;
    logic [7:0] t1_ctrl_q;

    // Bus handshake
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic irq_q;
    logic access;
    logic wr_en;
    logic wr_byte;
    logic [7:0] wdata;
    logic mapped;
    logic [7:0] rdata;

    // Per-register write selects
    logic we_cap_low;
    logic we_cap_high;
    logic we_ctrl;
    logic we_core;
    logic we_en;
    logic we_flags;
    logic we_t2_per;
    logic we_t1_low;
    logic we_t1_high;
    logic we_t2_cnt;
    logic we_dir;
    logic we_data;
    logic we_t1_ctrl;

    // Capture path
    logic [3:0] unit_mode;
    logic capture_active;
    logic pin_level;
    logic cap_event;
    logic [15:0] t1_count;

    // Two-cycle access: pready rises one cycle into the access phase
    assign access = psel_i && penable_i;
    assign wr_en = access && pready_q && pwrite_i;
    assign wr_byte = wr_en && pstrb_i[0];
    assign wdata = pwdata_i[7:0];

    // Decoded once so every register block sees the same strobe
    assign we_cap_low = wr_byte && paddr_i == capture_pkg::OFF_CAP_LOW;
    assign we_cap_high = wr_byte && paddr_i == capture_pkg::OFF_CAP_HIGH;
    assign we_ctrl = wr_byte && paddr_i == capture_pkg::OFF_UNIT_CTRL;
    assign we_core = wr_byte && paddr_i == capture_pkg::OFF_CORE_IRQ;
    assign we_en = wr_byte && paddr_i == capture_pkg::OFF_PERIPH_EN;
    assign we_flags = wr_byte && paddr_i == capture_pkg::OFF_PERIPH_FLAGS;
    assign we_t2_per = wr_byte && paddr_i == capture_pkg::OFF_T2_PERIOD;
    assign we_t1_low = wr_byte && paddr_i == capture_pkg::OFF_T1_LOW;
    assign we_t1_high = wr_byte && paddr_i == capture_pkg::OFF_T1_HIGH;
    assign we_t2_cnt = wr_byte && paddr_i == capture_pkg::OFF_T2_COUNT;
    assign we_dir = wr_byte && paddr_i == capture_pkg::OFF_PORTB_DIR;
    assign we_data = wr_byte && paddr_i == capture_pkg::OFF_PORTB_DATA;
    assign we_t1_ctrl = wr_byte && paddr_i == capture_pkg::OFF_T1_CTRL;

    always_comb
    begin
        mapped = 1'b1;
        case (paddr_i)
            capture_pkg::OFF_CAP_LOW: rdata = cap_low_q;
            capture_pkg::OFF_CAP_HIGH: rdata = cap_high_q;
            capture_pkg::OFF_UNIT_CTRL: rdata = unit_ctrl_q;
            capture_pkg::OFF_CORE_IRQ: rdata = core_irq_q;
            capture_pkg::OFF_PERIPH_EN: rdata = periph_en_q;
            capture_pkg::OFF_PERIPH_FLAGS: rdata = periph_flags_q;
            capture_pkg::OFF_T2_PERIOD: rdata = t2_period_q;
            capture_pkg::OFF_T1_LOW: rdata = t1_count[7:0];
            capture_pkg::OFF_T1_HIGH: rdata = t1_count[15:8];
            capture_pkg::OFF_T2_COUNT: rdata = t2_count_q;
            capture_pkg::OFF_PORTB_DIR: rdata = portb_dir_q;
            capture_pkg::OFF_PORTB_DATA: rdata = portb_data_q;
            capture_pkg::OFF_T1_CTRL: rdata = t1_ctrl_q;
            default:
            begin
                rdata = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            pready_q <= access && !pready_q;
            pslverr_q <= access && !pready_q && !mapped;
            prdata_q <= {24'h000000, rdata};
        end
    end

    // Capture pair: hardware capture wins over a same-cycle write
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cap_low_q <= capture_pkg::RST_CAPTURE;
        end
        else if (cap_event)
        begin
            cap_low_q <= t1_count[7:0];
        end
        else if (we_cap_low)
        begin
            cap_low_q <= wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cap_high_q <= capture_pkg::RST_CAPTURE;
        end
        else if (cap_event)
        begin
            cap_high_q <= t1_count[15:8];
        end
        else if (we_cap_high)
        begin
            cap_high_q <= wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            unit_ctrl_q <= capture_pkg::RST_UNIT_CTRL;
        end
        else if (we_ctrl)
        begin
            unit_ctrl_q <= wdata;
        end
    end

    // Plain storage: no effect on the interrupt output
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            core_irq_q <= capture_pkg::RST_CORE_IRQ;
        end
        else if (we_core)
        begin
            core_irq_q <= wdata;
        end
    end

    // Unimplemented enable bits read back as zero
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            periph_en_q <= capture_pkg::RST_PERIPH_EN;
        end
        else if (we_en)
        begin
            periph_en_q <= wdata & capture_pkg::PERIPH_MASK;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            t2_period_q <= capture_pkg::RST_T2_PERIOD;
        end
        else if (we_t2_per)
        begin
            t2_period_q <= wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            t2_count_q <= capture_pkg::RST_T2_COUNT;
        end
        else if (we_t2_cnt)
        begin
            t2_count_q <= wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            portb_dir_q <= capture_pkg::RST_PORTB_DIR;
        end
        else if (we_dir)
        begin
            portb_dir_q <= wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            portb_data_q <= capture_pkg::RST_PORTB_DATA;
        end
        else if (we_data)
        begin
            portb_data_q <= wdata;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            t1_ctrl_q <= capture_pkg::RST_T1_CTRL;
        end
        else if (we_t1_ctrl)
        begin
            t1_ctrl_q <= wdata;
        end
    end

    // Flags clear only by writing ones; a same-cycle capture still sets
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            periph_flags_q <= capture_pkg::RST_PERIPH_FLAGS;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (i == capture_pkg::CAP_FLAG_BIT && cap_event)
                begin
                    periph_flags_q[i] <= 1'b1;
                end
                else if (we_flags && wdata[i])
                begin
                    periph_flags_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(periph_flags_q & periph_en_q);
        end
    end

    // Duty bits 5:4 never reach the capture path
    assign unit_mode = unit_ctrl_q[capture_pkg::MODE_LSB +: 4];
    assign capture_active =
        (unit_mode[3:2] == capture_pkg::CAPTURE_GROUP);

    // Output pin: the driven latch is what the edge logic sees
    assign pin_level = portb_dir_q[capture_pkg::PIN_BIT] ?
        capture_pin_i : portb_data_q[capture_pkg::PIN_BIT];

    edge_prescaler u_prescaler
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .clear_i(!capture_active),
        .select_i(unit_mode[1:0]),
        .level_i(pin_level),
        .event_o(cap_event)
    );

    timer1_counter u_timer1
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(t1_ctrl_q[capture_pkg::T1_ENABLE_BIT]),
        .load_low_i(we_t1_low),
        .load_high_i(we_t1_high),
        .load_data_i(wdata),
        .count_o(t1_count)
    );

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign capture_pin_o = portb_data_q[capture_pkg::PIN_BIT];
    assign capture_pin_oe_o = ~portb_dir_q[capture_pkg::PIN_BIT];
    assign irq_o = irq_q;

endmodule : capture_unit

/* capture_pkg.sv */
// Purpose: Shared constants for the input capture unit.
// Assumes: 32-bit APB data, one register per aligned word.
// Notes: Register bytes sit in the low eight bits of each word.
package capture_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CAP_LOW = 8'h00;
    localparam logic [7:0] OFF_CAP_HIGH = 8'h04;
    localparam logic [7:0] OFF_UNIT_CTRL = 8'h08;
    localparam logic [7:0] OFF_CORE_IRQ = 8'h0c;
    localparam logic [7:0] OFF_PERIPH_EN = 8'h10;
    localparam logic [7:0] OFF_PERIPH_FLAGS = 8'h14;
    localparam logic [7:0] OFF_T2_PERIOD = 8'h18;
    localparam logic [7:0] OFF_T1_LOW = 8'h1c;
    localparam logic [7:0] OFF_T1_HIGH = 8'h20;
    localparam logic [7:0] OFF_T2_COUNT = 8'h24;
    localparam logic [7:0] OFF_PORTB_DIR = 8'h28;
    localparam logic [7:0] OFF_PORTB_DATA = 8'h2c;
    localparam logic [7:0] OFF_T1_CTRL = 8'h30;

    // Field positions
    localparam int MODE_LSB = 0;
    localparam int DUTY_LSB = 4;
    localparam int CAP_FLAG_BIT = 2;
    localparam int PIN_BIT = 3;
    localparam int T1_ENABLE_BIT = 0;

    // Implemented bits of the enable register
    localparam logic [7:0] PERIPH_MASK = 8'h47;

    // Reset values
    localparam logic [7:0] RST_UNIT_CTRL = 8'h00;
    localparam logic [7:0] RST_CORE_IRQ = 8'h00;
    localparam logic [7:0] RST_PERIPH_EN = 8'h00;
    localparam logic [7:0] RST_PERIPH_FLAGS = 8'h00;
    localparam logic [7:0] RST_T2_PERIOD = 8'hff;
    localparam logic [7:0] RST_T2_COUNT = 8'h00;
    localparam logic [7:0] RST_PORTB_DIR = 8'hff;
    localparam logic [7:0] RST_PORTB_DATA = 8'h00;
    localparam logic [7:0] RST_T1_CTRL = 8'h00;
    localparam logic [7:0] RST_CAPTURE = 8'h00;
    localparam logic [15:0] RST_T1_COUNT = 16'h0000;

    // Unit mode field encodings
    typedef enum logic [3:0] {
        MODE_OFF = 4'b0000,
        MODE_CAP_FALL = 4'b0100,
        MODE_CAP_RISE = 4'b0101,
        MODE_CAP_RISE4 = 4'b0110,
        MODE_CAP_RISE16 = 4'b0111
    } unit_mode_t;

    // Upper two mode bits that mark a capture mode
    localparam logic [1:0] CAPTURE_GROUP = 2'b01;

    // Edge select, low two mode bits
    localparam logic [1:0] SEL_FALL = 2'b00;
    localparam logic [1:0] SEL_RISE = 2'b01;
    localparam logic [1:0] SEL_RISE4 = 2'b10;
    localparam logic [1:0] SEL_RISE16 = 2'b11;

    // Prescaler terminal counts
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hf;

endpackage : capture_pkg

/* timer1_counter.sv */
// Purpose: 16-bit timer count that software can load byte by byte.
// Assumes: Counts one step per clock while enabled.
// Notes: A byte load wins over the increment in the same cycle.
`timescale 1ns/100ps
module timer1_counter
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic enable_i,
    input wire logic load_low_i,
    input wire logic load_high_i,
    input wire logic [7:0] load_data_i,
    // Count
    output logic [15:0] count_o
);

    logic [15:0] count_q;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count_q <= capture_pkg::RST_T1_COUNT;
        end
        else if (load_low_i)
        begin
            count_q <= {count_q[15:8], load_data_i};
        end
        else if (load_high_i)
        begin
            count_q <= {load_data_i, count_q[7:0]};
        end
        else if (enable_i)
        begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign count_o = count_q;

endmodule : timer1_counter

/* edge_prescaler.sv */
// Purpose: Edge detection and event prescaling for the capture pin.
// Assumes: level_i is already synchronous to clk_i.
// Notes: event_o is a one-cycle pulse, one clock after the edge.
`timescale 1ns/100ps
module edge_prescaler
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic clear_i,
    input wire logic [1:0] select_i,
    // Pin level
    input wire logic level_i,
    // Event
    output logic event_o
);

    logic level_q;
    logic [3:0] count_q;
    logic event_q;
    logic rise;
    logic fall;

    assign rise = level_i & ~level_q;
    assign fall = ~level_i & level_q;

    // Keeps tracking the level so mode writes cannot fake an old edge
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            level_q <= 1'b0;
        end
        else
        begin
            level_q <= level_i;
        end
    end

    // Counter survives switching between capture settings
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            count_q <= 4'h0;
        end
        else if (rise)
        begin
            count_q <= count_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            event_q <= 1'b0;
        end
        else
        begin
            case (select_i)
                capture_pkg::SEL_FALL: event_q <= fall;
                capture_pkg::SEL_RISE: event_q <= rise;
                capture_pkg::SEL_RISE4:
                    event_q <= rise &&
                        (count_q[1:0] == capture_pkg::PRESCALE_4_LAST[1:0]);
                capture_pkg::SEL_RISE16:
                    event_q <= rise &&
                        (count_q == capture_pkg::PRESCALE_16_LAST);
                default: event_q <= 1'b0;
            endcase
        end
    end

    assign event_o = event_q;

endmodule : edge_prescaler

/* capture_unit_sva.sv */
// Purpose: Port checker for capture_unit.
// Assumes: Only the capture enable bit is ever set in the enable register.
// Notes: Mode, enable and direction are shadowed from APB writes.
`timescale 1ns/100ps
module capture_unit_sva
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Pin and interrupt
    input wire logic capture_pin_i,
    input wire logic capture_pin_o,
    input wire logic capture_pin_oe_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    logic wr;
    logic [3:0] mode_q;
    logic en_q;
    logic dir_q;
    assign wr = psel_i & penable_i & pwrite_i & pready_o & pstrb_i[0];
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            mode_q <= 4'h0;
            en_q <= 1'b0;
            dir_q <= 1'b1;
        end
        else if (wr)
        begin
            if (paddr_i == capture_pkg::OFF_UNIT_CTRL)
                mode_q <= pwdata_i[3:0];
            if (paddr_i == capture_pkg::OFF_PERIPH_EN)
                en_q <= pwdata_i[2];
            if (paddr_i == capture_pkg::OFF_PORTB_DIR)
                dir_q <= pwdata_i[3];
        end
    end
    sequence s_rise_seen;
        mode_q == 4'h5 && en_q && !capture_pin_oe_o && $rose(capture_pin_i);
    endsequence
    sequence s_fall_seen;
        mode_q == 4'h4 && en_q && !capture_pin_oe_o && $fell(capture_pin_i);
    endsequence
    // Flag write-one while the unit has been off for two cycles
    sequence s_flag_clear;
        wr && paddr_i == capture_pkg::OFF_PERIPH_FLAGS && pwdata_i[2]
            && mode_q == 4'h0 && $past(mode_q) == 4'h0;
    endsequence
    sequence s_hold(logic [3:0] m);
        (mode_q == m && en_q) [*2];
    endsequence
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready held beyond one cycle");
    a_ready_wait: assert property (psel_i && penable_i && !$past(penable_i)
        |-> !pready_o ##1 pready_o)
        else $error("pready not in second access cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_rise_capture: assert property (s_rise_seen ##1 s_hold(4'h5)
        |=> irq_o)
        else $error("rising edge gave no interrupt");
    a_fall_capture: assert property (s_fall_seen ##1 s_hold(4'h4)
        |=> irq_o)
        else $error("falling edge gave no interrupt");
    a_irq_enable: assert property (irq_o |-> $past(en_q))
        else $error("interrupt while masked");
    // Flag drops at the write edge, the registered interrupt one later
    a_clear_drop: assert property (s_flag_clear |-> ##2 !irq_o)
        else $error("flag clear left interrupt high");
    a_oe_dir: assert property (capture_pin_oe_o == !dir_q)
        else $error("pin drive disagrees with direction");
endmodule : capture_unit_sva

bind capture_unit capture_unit_sva i_sva (.clk_i, .reset_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
    .pready_o, .pslverr_o, .capture_pin_i, .capture_pin_o,
    .capture_pin_oe_o, .irq_o);

/* pin_source.sv */
// Purpose: External signal source on the capture pin.
// Assumes: No pull on the pin; the source lets go while the unit drives.
// Notes: Requested levels land one clock late, like a slow driver.
`timescale 1ns/100ps
module pin_source
(
    // Clock
    input wire logic clk_i,
    // Requested level and the unit's drive
    input wire logic level_i,
    input wire logic unit_pin_i,
    input wire logic unit_oe_i,
    // Resolved pin
    output logic pin_o
);
    logic level_q;
    always_ff @(posedge clk_i)
        level_q <= level_i;
    // The unit's driver wins, so port writes reach the pin
    assign pin_o = unit_oe_i ? unit_pin_i : level_q;
endmodule : pin_source

/* capture_unit_tb.sv */
// Purpose: Self-checking bench for capture_unit.
// Assumes: Timer1 is stopped during captures, so each value is known.
// Notes: The model tracks mode, prescaler count, flag and capture.
`timescale 1ns/100ps
module capture_unit_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'hf;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, pin, pin_o, pin_oe, irq_o, err;
    logic level = 1'b0;
    logic [31:0] seed = 32'd77537;
    logic [31:0] rd;
    int n_fail = 0;
    int cmp_count = 0;
    int mode = 0;
    int pcnt = 0;
    int flag = 0;
    int timer = 0;
    int cap = 0;
    int modes[6] = '{4, 5, 6, 7, 106, 6};
    logic [7:0] roff[4] = '{8'h08, 8'h10, 8'h18, 8'h28};
    logic [7:0] rval[4] = '{8'h00, 8'h00, 8'hff, 8'hff};
    always #2 clk_i = ~clk_i;
    capture_unit i_dut (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
        .pslverr_o, .capture_pin_i(pin), .capture_pin_o(pin_o),
        .capture_pin_oe_o(pin_oe), .irq_o);
    pin_source i_src (.clk_i, .level_i(level), .unit_pin_i(pin_o),
        .unit_oe_i(pin_oe), .pin_o(pin));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 40);
        chk("pready", 1, n < 40);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input int e, input string nm);
        apb(1'b0, a, 0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic model(input int rise);
        int hit;
        hit = (mode == 4) ? !rise : rise && (mode == 5 ||
            (mode == 6 && pcnt % 4 == 3) || (mode == 7 && pcnt % 16 == 15));
        if (rise && mode >= 4)
            pcnt++;
        if (hit)
        begin
            flag = 1;
            cap = timer;
        end
    endtask : model
    task automatic pulse();
        int rise;
        rise = !level;
        timer = xs() & 32'hffff;
        apb(1'b1, capture_pkg::OFF_T1_LOW, timer & 255);
        apb(1'b1, capture_pkg::OFF_T1_HIGH, timer >> 8);
        level <= rise;
        repeat (8) @(posedge clk_i);
        model(rise);
        if (xs() & 1)
        begin
            rdchk(capture_pkg::OFF_CAP_LOW, cap & 255, "cap_low");
            rdchk(capture_pkg::OFF_CAP_HIGH, cap >> 8, "cap_high");
        end
        rdchk(8'h14, flag * 4, "flag");
        chk("irq", flag, irq_o);
        if (xs() & 2)
        begin
            apb(1'b1, 8'h14, 4);
            flag = 0;
        end
    endtask : pulse
    task automatic set_mode(input int m);
        int d;
        d = (m % 100) | ((xs() & 3) << 4);
        if (m < 100)
        begin
            apb(1'b1, capture_pkg::OFF_UNIT_CTRL, 0);
            apb(1'b1, 8'h14, 4);
            pcnt = 0;
            flag = 0;
        end
        apb(1'b1, capture_pkg::OFF_UNIT_CTRL, d);
        rdchk(capture_pkg::OFF_UNIT_CTRL, d, "ctrl");
        mode = m % 100;
    endtask : set_mode
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial
    begin
        #40000;
        $display("Error watchdog expected done seen hang");
        n_fail++;
        final_report();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        foreach (roff[i])
            rdchk(roff[i], rval[i], "reset_value");
        rdchk(8'h14, 0, "flags_reset");
        apb(1'b0, 8'h3c, 0);
        chk("unmapped_data", 0, rd);
        chk("unmapped_err", 1, err);
        // A write without its low byte strobe must leave the register
        pstrb_i <= 4'he;
        apb(1'b1, capture_pkg::OFF_T2_PERIOD, 8'h12);
        pstrb_i <= 4'hf;
        rdchk(capture_pkg::OFF_T2_PERIOD, capture_pkg::RST_T2_PERIOD,
            "strobe_off");
        // Enable lands at one write edge, disable four clocks later
        apb(1'b1, capture_pkg::OFF_T1_CTRL, 1);
        apb(1'b1, capture_pkg::OFF_T1_CTRL, 0);
        rdchk(capture_pkg::OFF_T1_LOW, 4, "timer_run");
        apb(1'b1, capture_pkg::OFF_PORTB_DIR, 8'hff);
        apb(1'b1, capture_pkg::OFF_PERIPH_EN, 4);
        foreach (modes[i])
        begin
            set_mode(modes[i]);
            repeat (18) pulse();
        end
        set_mode(5);
        while (!flag)
            pulse();
        apb(1'b1, capture_pkg::OFF_PERIPH_EN, 0);
        repeat (2) @(posedge clk_i);
        chk("irq_masked", 0, irq_o);
        apb(1'b1, capture_pkg::OFF_PERIPH_EN, 4);
        repeat (2) @(posedge clk_i);
        chk("irq_unmasked", 1, irq_o);
        apb(1'b1, 8'h14, 4);
        repeat (2) @(posedge clk_i);
        chk("irq_cleared", 0, irq_o);
        set_mode(5);
        apb(1'b1, capture_pkg::OFF_PORTB_DATA, 0);
        apb(1'b1, capture_pkg::OFF_PORTB_DIR, 8'hf7);
        apb(1'b1, capture_pkg::OFF_PORTB_DATA, 8'h08);
        repeat (8) @(posedge clk_i);
        model(1);
        chk("pin_out", 1, pin_o);
        rdchk(8'h14, 4, "port_flag");
        rdchk(capture_pkg::OFF_CAP_HIGH, cap >> 8, "port_cap");
        final_report();
    end
endmodule : capture_unit_tb
